// ===== rtl/mies_pkg.sv
package mies_pkg;
  // ==========================================
  // machine cycle timing
  localparam int CLKS_PER_MC = 4; // system clocks per machine cycle
  localparam logic [1:0] MC_LAST = 2'(CLKS_PER_MC - 1); // last clock of a machine cycle
  localparam logic [1:0] MC_BASE = 2'h1; // machine cycles of most instructions
  localparam logic [1:0] MC_RETURN = 2'h2; // machine cycles of the return family
  localparam logic [1:0] MC_PCL_EXTRA = 2'h1; // penalty for writing the pc low byte
  // ==========================================
  // addresses and values after reset
  localparam int PCL_ADDR = 2; // data address of the program_counter_low_byte
  localparam logic [7:0] WORK_RST = 8'h00; // working_register after reset
  localparam logic FLAG_RST = 1'b0; // every flag after reset
  // ==========================================
  // bcd_adjust constants
  localparam logic [3:0] NIB_MAX = 4'h9; // largest legal bcd digit
  localparam logic [3:0] BCD_FIX = 4'h6; // correction added to a digit
  // ==========================================
  // executed operations
  typedef enum logic [4:0] {
    OP_PRECLR_A = 5'h00, // first_preclear_cmd
    OP_PRECLR_B = 5'h01, // second_preclear_cmd
    OP_INV_MEM = 5'h02, // ones_complement_memory
    OP_INV_W = 5'h03, // ones_complement_to_working
    OP_BCD = 5'h04, // bcd_adjust
    OP_SUB1_MEM = 5'h05, // minus_one_from_memory
    OP_SUB1_W = 5'h06, // minus_one_into_working
    OP_ADD1_MEM = 5'h07, // plus one into memory
    OP_ADD1_W = 5'h08, // plus_one_into_working
    OP_HALT = 5'h09, // enter power down
    OP_JUMP = 5'h0a, // direct_jump
    OP_LOAD_WM = 5'h0b, // copy_data memory to working
    OP_LOAD_WI = 5'h0c, // copy_data immediate to working
    OP_STORE_W = 5'h0d, // copy_data working to memory
    OP_IDLE = 5'h0e, // idle_instruction
    OP_UNION_WM = 5'h0f, // or memory into working
    OP_UNION_WI = 5'h10, // or immediate into working
    OP_UNION_MEM = 5'h11, // bitwise_union_in_ram
    OP_EXIT_SUB = 5'h12, // subroutine_exit
    OP_EXIT_SUBV = 5'h13, // subroutine_exit with value
    OP_EXIT_IRQ = 5'h14, // interrupt_exit
    OP_ROL_MEM = 5'h15, // rotate_left_memory
    OP_ROL_W = 5'h16 // rotate_left_into_working
  } mies_op_t;
  // sequencer states, gray along idle -> exec -> halt
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_HALT = 2'h3
  } mies_state_t;
  // ==========================================
  // decoding helpers
  function automatic logic writes_mem(input mies_op_t op);
    writes_mem = op inside {OP_INV_MEM, OP_BCD, OP_SUB1_MEM, OP_ADD1_MEM,
                            OP_STORE_W, OP_UNION_MEM, OP_ROL_MEM};
  endfunction : writes_mem
  function automatic logic writes_w(input mies_op_t op);
    writes_w = op inside {OP_INV_W, OP_SUB1_W, OP_ADD1_W, OP_LOAD_WM, OP_LOAD_WI,
                          OP_UNION_WM, OP_UNION_WI, OP_EXIT_SUBV, OP_ROL_W};
  endfunction : writes_w
  function automatic logic sets_zero(input mies_op_t op);
    sets_zero = op inside {OP_INV_MEM, OP_INV_W, OP_SUB1_MEM, OP_SUB1_W, OP_ADD1_MEM,
                           OP_ADD1_W, OP_UNION_WM, OP_UNION_WI, OP_UNION_MEM};
  endfunction : sets_zero
  function automatic logic is_return(input mies_op_t op);
    is_return = op inside {OP_EXIT_SUB, OP_EXIT_SUBV, OP_EXIT_IRQ};
  endfunction : is_return
  // data result: m memory byte, a working, x immediate, b bcd result
  function automatic logic [7:0] alu(input mies_op_t op, input logic [7:0] m,
                                     input logic [7:0] a, input logic [7:0] x,
                                     input logic [7:0] b);
    case (op)
      OP_INV_MEM, OP_INV_W: alu = ~m;
      OP_SUB1_MEM, OP_SUB1_W: alu = m - 8'h01;
      OP_ADD1_MEM, OP_ADD1_W: alu = m + 8'h01;
      OP_LOAD_WM: alu = m;
      OP_LOAD_WI, OP_EXIT_SUBV: alu = x;
      OP_STORE_W: alu = a;
      OP_UNION_WM, OP_UNION_MEM: alu = a | m;
      OP_UNION_WI: alu = a | x;
      OP_ROL_MEM, OP_ROL_W: alu = {m[6:0], m[7]};
      OP_BCD: alu = b;
      default: alu = 8'h00;
    endcase
  endfunction : alu
endpackage : mies_pkg

// ===== rtl/mies_core.sv
`timescale 1ns/1ps
module mies_core
  import mies_pkg::*;
#(
  parameter int PC_W = 10, // program counter width
  parameter int ADDR_W = 6, // data memory address width
  parameter int WDOG_W = 8, // watchdog counter width
  parameter int PRE_W = 8 // watchdog prescaler width
)(
  input wire logic REF_CLK, // system clock
  input wire logic RST_N, // asynchronous reset, active low
  input wire logic START, // issue an instruction when not busy
  input wire mies_op_t OPCODE, // operation to execute
  input wire logic [ADDR_W-1:0] MEM_ADDR, // data memory address of the operand
  input wire logic [7:0] MEM_RDATA, // operand byte read at that address
  input wire logic [7:0] IMM, // immediate byte
  input wire logic [PC_W-1:0] JUMP_ADDR, // target of a direct jump
  input wire logic [PC_W-1:0] STACK_TOP, // top of the return stack
  input wire logic FLAG_WR, // load carry and half carry while idle
  input wire logic [1:0] FLAG_WDATA, // {half carry, carry}
  input wire logic WAKE, // leave power down
  output logic BUSY, // instruction in flight or halted
  output logic DONE, // one cycle after an instruction retires
  output logic HALTED, // clock is stopped
  output logic STACK_POP, // pulse: a return consumed the stack top
  output logic [7:0] WORKING_REG, // working_register
  output logic ZERO, // zero flag
  output logic CARRY, // carry flag
  output logic HALF_CARRY, // half_carry_flag
  output logic GLOBAL_IRQ_ENABLE, // global_irq_enable
  output logic POWERDOWN_FLAG, // powerdown_flag
  output logic WATCHDOG_TIMEOUT_FLAG, // watchdog_timeout_flag
  output logic [WDOG_W-1:0] WATCHDOG_COUNTER, // watchdog_counter
  output logic PRECLEAR_A_SEEN, // first preclear waits for its partner
  output logic PRECLEAR_B_SEEN, // second preclear waits for its partner
  output logic MEM_WE, // data memory write strobe, one cycle
  output logic [ADDR_W-1:0] MEM_WADDR, // write address
  output logic [7:0] MEM_WDATA, // write data
  output logic [PC_W-1:0] PC // program counter
);
  // elaboration checks: a pc low byte write needs at least eight pc bits
  if (PC_W < 8 || PC_W > 16 || ADDR_W < 2 || WDOG_W < 1 || PRE_W < 1) begin : g_bad
    $error("mies_core: unsupported width parameters");
  end
  // ==========================================
  // sequencer signals
  mies_state_t state; // sequencer state
  mies_state_t next_state; // next sequencer state
  logic [1:0] mc_cnt; // clock within the machine cycle
  logic [1:0] left; // machine cycles still to run
  mies_op_t op_q; // latched operation
  logic [7:0] opnd; // latched memory operand
  logic [7:0] imm_q; // latched immediate
  logic [ADDR_W-1:0] addr_q; // latched address
  logic [PC_W-1:0] jmp_q; // latched jump target
  logic [PC_W-1:0] stk_q; // latched stack top
  logic [PRE_W-1:0] pre_cnt; // watchdog prescaler
  wire tick = mc_cnt == MC_LAST; // last clock of a machine cycle
  wire take = START && state == ST_IDLE; // request accepted
  wire commit = state == ST_EXEC && tick && left == 2'h1; // instruction retires
  wire pcl_hit = writes_mem(OPCODE) && MEM_ADDR == ADDR_W'(PCL_ADDR); // new pc low write
  wire pcl_q = writes_mem(op_q) && addr_q == ADDR_W'(PCL_ADDR); // latched pc low write
  wire [1:0] base_mc = is_return(OPCODE) ? MC_RETURN : MC_BASE;
  wire [1:0] need_mc = base_mc + (pcl_hit ? MC_PCL_EXTRA : 2'h0);
  // ==========================================
  // bcd adjust datapath
  wire low_fix = WORKING_REG[3:0] > NIB_MAX || HALF_CARRY;
  wire [4:0] lo_sum = {1'b0, WORKING_REG[3:0]} + (low_fix ? {1'b0, BCD_FIX} : 5'h00);
  wire [4:0] hi_base = {1'b0, WORKING_REG[7:4]} + {4'h0, low_fix}; // low_fix added into the high digit
  wire hi_fix = hi_base > {1'b0, NIB_MAX} || CARRY;
  wire [4:0] hi_sum = hi_base + (hi_fix ? {1'b0, BCD_FIX} : 5'h00);
  wire [7:0] bcd_res = {hi_sum[3:0], lo_sum[3:0]};
  wire [7:0] res = alu(op_q, opnd, WORKING_REG, imm_q, bcd_res); // shared result
  // watchdog events
  wire wd_tick = tick && state != ST_HALT; // counts machine cycles while running
  wire pre_wrap = &pre_cnt; // prescaler about to wrap
  wire wdt_ovf = wd_tick && pre_wrap && &WATCHDOG_COUNTER; // time-out event
  wire halt_now = commit && op_q == OP_HALT;
  wire pair_clr = commit && ((op_q == OP_PRECLR_A && PRECLEAR_B_SEEN) ||
                             (op_q == OP_PRECLR_B && PRECLEAR_A_SEEN));
  // ==========================================
  // next state decode
  assign next_state = (state == ST_IDLE && take) ? ST_EXEC :
                      (state == ST_EXEC && commit) ? (halt_now ? ST_HALT : ST_IDLE) :
                      (state == ST_HALT && WAKE) ? ST_IDLE :
                      (state == ST_EXEC || state == ST_HALT) ? state : ST_IDLE;
  // sequencer and status outputs
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      BUSY <= 1'b0;
      HALTED <= 1'b0;
      DONE <= 1'b0;
      STACK_POP <= 1'b0;
      MEM_WE <= 1'b0;
    end
    else
    begin
      state <= next_state;
      BUSY <= next_state != ST_IDLE;
      HALTED <= next_state == ST_HALT;
      DONE <= commit;
      STACK_POP <= commit && is_return(op_q);
      MEM_WE <= commit && writes_mem(op_q);
    end
  end
  // machine cycle divider, restarted per instruction so lengths are exact
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      mc_cnt <= 2'h0;
    else if (take)
      mc_cnt <= 2'h0;
    else if (state != ST_HALT) // system clock is off in power down
      mc_cnt <= mc_cnt + 2'h1;
  end
  // remaining machine cycles
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      left <= 2'h0;
    else if (take)
      left <= need_mc;
    else if (state == ST_EXEC && tick)
      left <= left - 2'h1;
  end
  // operand capture; no reset needed, every use of these latches is gated by commit
  always_ff @(posedge REF_CLK)
  begin
    if (take)
    begin
      op_q <= OPCODE;
      opnd <= MEM_RDATA;
      imm_q <= IMM;
      addr_q <= MEM_ADDR;
      jmp_q <= JUMP_ADDR;
      stk_q <= STACK_TOP;
    end
  end
  // ==========================================
  // watchdog prescaler, frozen while halted like the system clock
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pre_cnt <= '0;
    else if (halt_now)
      pre_cnt <= '0;
    else if (wd_tick)
      pre_cnt <= pre_cnt + 1'b1;
  end
  // watchdog counter, power flags, preclear marks; a time-out in the clearing cycle wins
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WATCHDOG_COUNTER <= '0;
      WATCHDOG_TIMEOUT_FLAG <= FLAG_RST;
      POWERDOWN_FLAG <= FLAG_RST;
      PRECLEAR_A_SEEN <= 1'b0;
      PRECLEAR_B_SEEN <= 1'b0;
    end
    else
    begin
      if (halt_now || pair_clr)
        WATCHDOG_COUNTER <= '0;
      else if (wd_tick && pre_wrap)
        WATCHDOG_COUNTER <= WATCHDOG_COUNTER + 1'b1;
      if (wdt_ovf)
        WATCHDOG_TIMEOUT_FLAG <= 1'b1;
      else if (pair_clr || halt_now)
        WATCHDOG_TIMEOUT_FLAG <= 1'b0;
      if (halt_now)
        POWERDOWN_FLAG <= 1'b1;
      else if (pair_clr)
        POWERDOWN_FLAG <= 1'b0;
      if (pair_clr || halt_now) // a repeated half only re-marks itself
      begin
        PRECLEAR_A_SEEN <= 1'b0;
        PRECLEAR_B_SEEN <= 1'b0;
      end
      else if (commit && op_q == OP_PRECLR_A)
        PRECLEAR_A_SEEN <= 1'b1;
      else if (commit && op_q == OP_PRECLR_B)
        PRECLEAR_B_SEEN <= 1'b1;
    end
  end
  // ==========================================
  // architectural registers; flags outside each op's set are held
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WORKING_REG <= WORK_RST;
      ZERO <= FLAG_RST;
      CARRY <= FLAG_RST;
      HALF_CARRY <= FLAG_RST;
      GLOBAL_IRQ_ENABLE <= FLAG_RST;
    end
    else
    begin
      if (commit && writes_w(op_q))
        WORKING_REG <= res;
      if (commit && sets_zero(op_q))
        ZERO <= res == 8'h00;
      if (commit && op_q == OP_BCD && hi_fix)
        CARRY <= 1'b1;
      else if (FLAG_WR && state == ST_IDLE)
        CARRY <= FLAG_WDATA[0];
      if (FLAG_WR && state == ST_IDLE)
        HALF_CARRY <= FLAG_WDATA[1];
      if (commit && op_q == OP_EXIT_IRQ)
        GLOBAL_IRQ_ENABLE <= 1'b1;
    end
  end
  // program counter; a pc low write replaces the low byte instead
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      PC <= '0;
    else if (commit && op_q == OP_JUMP)
      PC <= jmp_q;
    else if (commit && is_return(op_q))
      PC <= stk_q;
    else if (commit && pcl_q)
      PC <= {PC[PC_W-1:8], res};
    else if (commit)
      PC <= PC + 1'b1;
  end
  // data memory write address and data, held after the strobe
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      MEM_WADDR <= '0;
      MEM_WDATA <= 8'h00;
    end
    else if (commit)
    begin
      MEM_WADDR <= addr_q;
      MEM_WDATA <= res;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_take(mies_op_t o);
    take && OPCODE == o;
  endsequence
  sequence s_one_mc;
    !commit [*3] ##1 commit;
  endsequence
  property p_pair;
    commit && op_q == OP_PRECLR_B && PRECLEAR_A_SEEN && !wdt_ovf |=>
      WATCHDOG_COUNTER == '0 && !WATCHDOG_TIMEOUT_FLAG && !POWERDOWN_FLAG;
  endproperty
  a_pair: assert property (p_pair) else $error("preclear pair did not clear");
  property p_single;
    commit && op_q == OP_PRECLR_A && !PRECLEAR_B_SEEN && !wdt_ovf |=>
      PRECLEAR_A_SEEN && $stable(POWERDOWN_FLAG) && $stable(WATCHDOG_TIMEOUT_FLAG);
  endproperty
  a_single: assert property (p_single) else $error("single preclear changed flags");
  property p_inv_mem;
    commit && op_q == OP_INV_MEM |=>
      MEM_WE && MEM_WDATA == ~$past(opnd) && ZERO == (MEM_WDATA == 8'h00) && $stable(CARRY);
  endproperty
  a_inv_mem: assert property (p_inv_mem) else $error("memory complement wrong");
  property p_inv_w;
    commit && op_q == OP_INV_W |=> !MEM_WE && WORKING_REG == ~$past(opnd);
  endproperty
  a_inv_w: assert property (p_inv_w) else $error("working complement wrong");
  property p_bcd_low;
    commit && op_q == OP_BCD && WORKING_REG == 8'h0b && !HALF_CARRY && !CARRY |=>
      MEM_WE && MEM_WDATA == 8'h11 && !CARRY;
  endproperty
  a_bcd_low: assert property (p_bcd_low) else $error("low digit adjust wrong");
  property p_bcd_high;
    commit && op_q == OP_BCD && WORKING_REG == 8'ha0 && !HALF_CARRY |=>
      MEM_WE && MEM_WDATA == 8'h00 && CARRY;
  endproperty
  a_bcd_high: assert property (p_bcd_high) else $error("high digit adjust wrong");
  property p_dec;
    commit && op_q == OP_SUB1_W |=> WORKING_REG == $past(opnd) - 8'h01 && !MEM_WE;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_inc;
    commit && op_q == OP_ADD1_MEM |=> MEM_WDATA == $past(opnd) + 8'h01 && $stable(WORKING_REG);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_halt;
    commit && op_q == OP_HALT |=> HALTED && POWERDOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG &&
      WATCHDOG_COUNTER == '0 && PC == $past(PC) + 1'b1;
  endproperty
  a_halt: assert property (p_halt) else $error("halt effects wrong");
  property p_jump;
    s_take(OP_JUMP) |=> s_one_mc ##1 (PC == $past(jmp_q) && $stable(ZERO));
  endproperty
  a_jump: assert property (p_jump) else $error("jump wrong");
  property p_ret_len;
    s_take(OP_EXIT_SUB) |=> !commit [*7] ##1 commit ##1 STACK_POP;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return length wrong");
  property p_interrupt_exit;
    commit && op_q == OP_EXIT_IRQ |=> GLOBAL_IRQ_ENABLE && PC == $past(stk_q);
  endproperty
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit wrong");
  property p_rol;
    commit && op_q == OP_ROL_MEM |=> MEM_WDATA == {$past(opnd[6:0]), $past(opnd[7])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate wrong");
  property p_pcl;
    take && pcl_hit && !is_return(OPCODE) |=> !commit [*7] ##1 commit;
  endproperty
  a_pcl: assert property (p_pcl) else $error("pc low write not stretched");
endmodule : mies_core

// ===== sim/mies_data_mem.sv
`timescale 1ns/1ps
// ==========
// data memory of the core: combinational read, write on the strobe
module mies_data_mem
#(
  parameter int ADDR_W = 6 // address width
)(
  input wire logic clk, // system clock
  input wire logic [ADDR_W-1:0] addr, // operand address
  output logic [7:0] rdata, // operand byte
  input wire logic we, // write strobe
  input wire logic [ADDR_W-1:0] waddr, // write address
  input wire logic [7:0] wdata // write data
);
  logic [7:0] mem [2**ADDR_W] = '{default: 8'h00}; // byte store
  // read is combinational because the core samples it with the request
  assign rdata = mem[addr];
  // write lands on the edge that sees the strobe
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
endmodule : mies_data_mem

// ===== sim/mies_core_tb.sv
`timescale 1ns/1ps
module mies_core_tb;
  import mies_pkg::*;
  // ==========
  // stimulus, outputs and shadow state
  logic ref_clk = 0, rst_n = 0, start = 0, flag_wr = 0, wake = 0; // driven inputs
  mies_op_t opcode = OP_IDLE; // operation
  logic [5:0] mem_addr = 6'h00, mem_waddr; // addresses
  logic [7:0] imm = 8'h00, mem_rdata, working_reg, mem_wdata, wdog; // bytes
  logic [9:0] jump_addr = 10'h000, stack_top = 10'h000, pc; // program addresses
  logic [1:0] flag_wdata = 2'h0; // {half carry, carry}
  logic busy, done, halted, stack_pop, zero, carry, hcar, gie, powerdown_flag, tof, pa, pb, mem_we;
  int mismatches = 0, comparisons = 0, cycles = 0; // score and watchdog of the run
  logic [7:0] sw = 8'h00, smem [64] = '{default: 8'h00}; // expected working and memory
  logic sz = 0, sc = 0, shc = 0, sgie = 0, spd = 0, sto = 0, spa = 0, spb = 0; // flags
  logic [9:0] spc = 10'h000; // expected pc
  // ==========
  // design and far side
  mies_core u_mies_core (.REF_CLK(ref_clk), .RST_N(rst_n), .START(start), .OPCODE(opcode),
    .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .IMM(imm), .JUMP_ADDR(jump_addr),
    .STACK_TOP(stack_top), .FLAG_WR(flag_wr), .FLAG_WDATA(flag_wdata), .WAKE(wake),
    .BUSY(busy), .DONE(done), .HALTED(halted), .STACK_POP(stack_pop),
    .WORKING_REG(working_reg), .ZERO(zero), .CARRY(carry), .HALF_CARRY(hcar),
    .GLOBAL_IRQ_ENABLE(gie), .POWERDOWN_FLAG(powerdown_flag), .WATCHDOG_TIMEOUT_FLAG(tof),
    .WATCHDOG_COUNTER(wdog), .PRECLEAR_A_SEEN(pa), .PRECLEAR_B_SEEN(pb), .MEM_WE(mem_we),
    .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .PC(pc));
  mies_data_mem u_mies_data_mem (.clk(ref_clk), .addr(mem_addr), .rdata(mem_rdata),
    .we(mem_we), .waddr(mem_waddr), .wdata(mem_wdata));
  // ==========
  // helpers
  task stop_test;
  begin
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : stop_test
  task chk(input logic [15:0] seen, input logic [15:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask : chk
  // carry and half carry can only be loaded while idle
  task setf(input logic h, input logic c);
  begin
    @(posedge ref_clk); #1 flag_wr = 1; flag_wdata = {h, c};
    @(posedge ref_clk); #1 flag_wr = 0; shc = h; sc = c;
  end
  endtask : setf
  // issue one operation, predict its effect, then compare cycle count, strobes, working register, pc, flags and the memory byte
  task automatic run(input mies_op_t op, input logic [5:0] a, input logic [7:0] x);
    logic [7:0] m, r;
    logic [4:0] hi;
    logic k, wm, ww, zf, ret, pr;
    int n, cyc;
  begin
    m = smem[a]; r = 8'h00; zf = 0; ret = 0; pr = 0;
    wm = op inside {OP_INV_MEM, OP_BCD, OP_SUB1_MEM, OP_ADD1_MEM, OP_STORE_W,
                    OP_UNION_MEM, OP_ROL_MEM};
    ww = op inside {OP_INV_W, OP_SUB1_W, OP_ADD1_W, OP_LOAD_WM, OP_LOAD_WI,
                    OP_UNION_WM, OP_UNION_WI, OP_EXIT_SUBV, OP_ROL_W};
    case (op)
      OP_INV_MEM, OP_INV_W: begin r = ~m; zf = 1; end
      OP_SUB1_MEM, OP_SUB1_W: begin r = m - 8'h01; zf = 1; end
      OP_ADD1_MEM, OP_ADD1_W: begin r = m + 8'h01; zf = 1; end
      OP_LOAD_WM: r = m;
      OP_LOAD_WI: r = x;
      OP_STORE_W: r = sw;
      OP_UNION_WM, OP_UNION_MEM: begin r = sw | m; zf = 1; end
      OP_UNION_WI: begin r = sw | x; zf = 1; end
      OP_ROL_MEM, OP_ROL_W: r = {m[6:0], m[7]};
      OP_EXIT_SUBV: begin r = x; ret = 1; end
      OP_EXIT_SUB, OP_EXIT_IRQ: ret = 1;
      OP_HALT: begin spd = 1; sto = 0; spa = 0; spb = 0; pr = 1; end
      OP_PRECLR_A, OP_PRECLR_B:
      begin
        pr = (op == OP_PRECLR_A) ? spb : spa;
        if (pr) {spa, spb, spd, sto} = 4'h0;
        else if (op == OP_PRECLR_A) spa = 1;
        else spb = 1;
      end
      OP_BCD:
      begin
        k = (sw[3:0] > 4'h9) || shc;
        r[3:0] = sw[3:0] + (k ? 4'h6 : 4'h0);
        hi = {1'b0, sw[7:4]} + 5'(k);
        if (hi > 5'h09 || sc) begin hi = hi + 5'h06; sc = 1; end
        r[7:4] = hi[3:0];
      end
      default: ;
    endcase
    if (zf) sz = (r == 8'h00);
    if (ww) sw = r;
    if (wm) smem[a] = r;
    if (op == OP_EXIT_IRQ) sgie = 1;
    n = (ret ? 2 : 1) + ((wm && a == PCL_ADDR) ? 1 : 0);
    if (op == OP_JUMP) spc = jump_addr;
    else if (ret) spc = stack_top;
    else if (wm && a == PCL_ADDR) spc = {spc[9:8], r};
    else spc = spc + 10'h001;
    @(posedge ref_clk); #1 start = 1; opcode = op; mem_addr = a; imm = x;
    @(posedge ref_clk); #1 start = 0; cyc = 0;
    while (done !== 1'b1 && halted !== 1'b1 && cyc < 40)
    begin
      @(posedge ref_clk); #1 cyc++;
    end
    if (op != OP_HALT) chk(cyc, 4 * n);
    if (op != OP_HALT) chk(stack_pop, ret);
    if (op != OP_HALT) chk(mem_we, wm);
    if (wm) chk({mem_waddr, mem_wdata}, {a, r});
    if (pr) chk(wdog, 8'h00);
    chk(working_reg, sw);
    chk(pc, spc);
    chk({zero, carry, hcar, gie, powerdown_flag, tof, pa, pb}, {sz, sc, shc, sgie, spd, sto, spa, spb});
    @(posedge ref_clk); #1 chk(u_mies_data_mem.mem[a], smem[a]);
  end
  endtask : run
  // ==========
  // clock, run limit and main sequence
  initial forever #2 ref_clk = ~ref_clk;
  initial forever
  begin
    @(posedge ref_clk) cycles++;
    if (cycles == 3000) begin mismatches++; stop_test; end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1;
    run(OP_LOAD_WI, 6'h00, 8'h80);
    run(OP_STORE_W, 6'h05, 8'h00);
    run(OP_ROL_MEM, 6'h05, 8'h00);
    run(OP_ROL_W, 6'h05, 8'h00);
    run(OP_INV_MEM, 6'h05, 8'h00);
    run(OP_INV_W, 6'h05, 8'h00);
    run(OP_ADD1_MEM, 6'h05, 8'h00);
    run(OP_ADD1_W, 6'h05, 8'h00);
    run(OP_ADD1_MEM, 6'h05, 8'h00);
    run(OP_SUB1_W, 6'h05, 8'h00);
    run(OP_SUB1_MEM, 6'h05, 8'h00);
    run(OP_LOAD_WI, 6'h00, 8'h0c);
    run(OP_STORE_W, 6'h06, 8'h00);
    run(OP_LOAD_WI, 6'h00, 8'h00);
    run(OP_UNION_WI, 6'h00, 8'h00);
    run(OP_UNION_WI, 6'h00, 8'h30);
    run(OP_UNION_WM, 6'h06, 8'h00);
    run(OP_UNION_MEM, 6'h06, 8'h00);
    run(OP_LOAD_WM, 6'h05, 8'h00);
    setf(0, 0);
    run(OP_LOAD_WI, 6'h00, 8'h9a);
    run(OP_BCD, 6'h07, 8'h00);
    setf(0, 1);
    run(OP_LOAD_WI, 6'h00, 8'h45);
    run(OP_BCD, 6'h07, 8'h00);
    setf(1, 0);
    run(OP_BCD, 6'h08, 8'h00);
    setf(0, 0);
    run(OP_LOAD_WI, 6'h00, 8'h0b);
    run(OP_BCD, 6'h09, 8'h00);
    run(OP_LOAD_WI, 6'h00, 8'ha0);
    run(OP_BCD, 6'h0a, 8'h00);
    run(OP_IDLE, 6'h00, 8'h00);
    jump_addr = 10'h3f0;
    run(OP_JUMP, 6'h00, 8'h00);
    stack_top = 10'h123;
    run(OP_EXIT_SUB, 6'h00, 8'h00);
    stack_top = 10'h055;
    run(OP_EXIT_SUBV, 6'h00, 8'h77);
    stack_top = 10'h200;
    run(OP_EXIT_IRQ, 6'h00, 8'h00);
    run(OP_LOAD_WI, 6'h00, 8'ha5);
    run(OP_STORE_W, 6'(PCL_ADDR), 8'h00);
    run(OP_INV_MEM, 6'(PCL_ADDR), 8'h00);
    run(OP_HALT, 6'h00, 8'h00);
    chk(halted, 1'b1);
    @(posedge ref_clk); #1 wake = 1;
    @(posedge ref_clk); #1 wake = 0;
    repeat (4) @(posedge ref_clk);
    #1 chk({halted, busy}, 2'h0);
    run(OP_PRECLR_A, 6'h00, 8'h00);
    run(OP_PRECLR_A, 6'h00, 8'h00);
    run(OP_PRECLR_B, 6'h00, 8'h00);
    run(OP_PRECLR_B, 6'h00, 8'h00);
    run(OP_PRECLR_A, 6'h00, 8'h00);
    stop_test;
  end
endmodule : mies_core_tb
